// ### touch_cfg_defines.svh
`ifndef TOUCH_CFG_DEFINES_SVH
`define TOUCH_CFG_DEFINES_SVH

// Register offsets
`define ADDR_TOUCH_SENS     8'h1F
`define ADDR_CFG_A          8'h20
`define ADDR_SAMPLE_EN      8'h21
`define ADDR_CFG_B          8'h44

// Reset values
`define RST_TOUCH_SENS      8'h2F
`define RST_CFG_A           8'h20
`define RST_SAMPLE_EN       8'h07
`define RST_CFG_B           8'h40

// Implemented bits of each register
`define MASK_TOUCH_SENS     8'h7F
`define MASK_CFG_A          8'hB8
`define MASK_SAMPLE_EN      8'h07
`define MASK_CFG_B          8'hFD

// Field positions
`define GAIN_LSB            4
`define BASE_LSB            0
`define BIT_TIMEOUT         7
`define BIT_DIG_OFF         5
`define BIT_LF_OFF          4
`define BIT_LONG_RECAL      3
`define BIT_LINK_INV        7
`define BIT_ALERT_POL       6
`define BIT_PWR_BLK         5
`define BIT_MIR_DECOUPLE    4
`define BIT_RF_ONLY         3
`define BIT_RF_OFF          2
`define BIT_REL_SUPP        0

// Scaling limits
`define GAIN_MAX_SHIFT      3'h7
`define BASE_MAX_SHIFT      4'h8

// Timing
`define CLK_MHZ             100
`define BUS_LOW_TIMEOUT_MS  30
`define BUS_IDLE_US         200
`define BUS_LOW_CYCLES      (`BUS_LOW_TIMEOUT_MS * 1000 * `CLK_MHZ)
`define BUS_IDLE_CYCLES     (`BUS_IDLE_US * `CLK_MHZ)
`define SLOT_CYCLES         8'h14

`endif

// ### touch_cfg_pkg.sv
package touch_cfg_pkg;

	typedef struct packed {
		logic               valid;
		logic [1:0]         chan;
		logic signed [15:0] raw;
		logic               lf_noise;
		logic               rf_noise;
		logic [7:0]         touch_thr;
		logic [7:0]         noise_thr;
	} sample_in_t;

	typedef struct packed {
		logic       valid;
		logic [1:0] chan;
		logic [7:0] delta;
		logic       touched;
		logic       recal_use;
		logic       noise_flag;
	} delta_out_t;

	typedef struct packed {
		logic [21:0] cnt;
		logic        fired;
		logic        expired;
	} hold_timer_t;

	typedef struct packed {
		logic       req;
		logic       busy;
		logic       is_read;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       ack_s1;
		logic       ack_s2;
		logic       ack_s3;
		logic [7:0] rdata;
		logic       rvalid;
	} link_state_t;

	typedef struct packed {
		logic [7:0]  sens;
		logic [7:0]  cfg_a;
		logic [7:0]  smp_en;
		logic [7:0]  cfg_b;
		logic        req_s1;
		logic        req_s2;
		logic        req_s3;
		logic        ack;
		logic [7:0]  rdata;
		logic        scl_s1;
		logic        scl_s2;
		logic        sda_s1;
		logic        sda_s2;
		logic        bus_timeout;
		logic        bus_idle_reset;
		delta_out_t  dout;
		logic [15:0] base_out;
		logic        base_out_valid;
		logic        recal_restart;
		logic        irq_event;
		logic        alert_out;
		logic        alert_oe;
		logic        link_touch_out;
		logic        duty_min_eq_max;
		logic        sense_powerdown;
		logic        mirror_load;
		logic [2:0]  mirror_value;
		logic        sample_start;
		logic [1:0]  sample_chan;
		logic        cycle_start;
		logic [7:0]  slot_cnt;
		logic [1:0]  slot_idx;
	} core_state_t;

endpackage : touch_cfg_pkg

// ### bus_hold_timer.sv
`timescale 1ns/1ps
`include "touch_cfg_defines.svh"

module bus_hold_timer #(
	parameter int unsigned LIMIT = 20000
) (
	input  wire logic clk,     // System clock
	input  wire logic srst,    // Synchronous reset
	input  wire logic enable,  // Watch enabled
	input  wire logic cond,    // Line condition being timed
	output logic      expired  // One-cycle pulse once held too long
);
	localparam logic [21:0] LIM = 22'(LIMIT);

	touch_cfg_pkg::hold_timer_t st;
	touch_cfg_pkg::hold_timer_t next_st;

	always_comb begin
		next_st = st;
		next_st.expired = 1'b0;
		if (!enable || !cond) begin
			next_st.cnt = 22'h0;
			next_st.fired = 1'b0;
		end else if (st.cnt >= LIM) begin
			// Fires once per hold, strictly after the limit
			next_st.expired = !st.fired;
			next_st.fired = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 22'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign expired = st.expired;

endmodule : bus_hold_timer

// ### touch_cfg_core.sv
`timescale 1ns/1ps
`include "touch_cfg_defines.svh"

// How it works
// - Gain code 0 to 7 scales delta by 128 down to 1, halving per step.
// - Base scale code n gives 2^n for 0..8, else 256; resets to 1111b.
// - Base scale touches only presented base counts, never detection.
// - Timeout enabled: clock low over 30 ms abandons the bus transaction.
// - Timeout enabled: both lines high over 200 us resets the interface idle.
// - Timeout disabled: neither clock-low timeout nor idle reset occurs.
// - Digital filter on: deltas between noise and touch thresholds skip recalibration.
// - Digital filter off (reset): every delta below touch threshold feeds recalibration.
// - Low-frequency filter on: detected low-frequency noise zeroes that delta.
// - Long-touch recalibration on: expired touch restarts recalibration; off ignores it.
// - Invert clear: min duty equals max; set: linked touch signal inverted.
// - Alert polarity clear: active high push-pull; set (reset): active low open drain.
// - Power block clear: power down after conversions; set keeps sensing powered.
// - Decouple clear: polarity writes copy into mirror bits; set blocks that.
// - RF-only clear: status shows RF and low-frequency noise; set: RF only.
// - RF filter on: detected RF noise zeroes that delta.
// - Interrupt on press, repeat and release; release skipped when suppression set.
// - Per-input enables gate sampling; all three set after reset.
// - Sampling cycle length is fixed regardless of enabled inputs.

module touch_cfg_core #(
	parameter int unsigned BUS_LOW_CYCLES  = `BUS_LOW_CYCLES,
	parameter int unsigned BUS_IDLE_CYCLES = `BUS_IDLE_CYCLES
) (
	input  wire logic                      clk,             // System clock
	input  wire logic                      srst,            // Reset, system domain
	input  wire logic                      link_clk,        // Serial engine clock
	input  wire logic                      link_srst,       // Reset, link domain
	input  wire logic                      link_wr,         // Register write request
	input  wire logic                      link_rd,         // Register read request
	input  wire logic [7:0]                link_addr,       // Register offset
	input  wire logic [7:0]                link_wdata,      // Write data
	output logic      [7:0]                link_rdata,      // Read data
	output logic                           link_rvalid,     // Read data valid pulse
	output logic                           link_busy,       // Access in flight
	input  wire logic                      scl_pin,         // Bus clock line level
	input  wire logic                      sda_pin,         // Bus data line level
	output logic                           bus_timeout,     // Clock-low timeout pulse
	output logic                           bus_idle_reset,  // Idle reset pulse
	input  wire touch_cfg_pkg::sample_in_t smp,             // Raw sample from front end
	output touch_cfg_pkg::delta_out_t      dout,            // Scaled delta result
	input  wire logic                      base_valid,      // Base count strobe
	input  wire logic [15:0]               base_count,      // Raw base count
	output logic      [15:0]               base_out,        // Presented base count
	output logic                           base_out_valid,  // Presented base strobe
	input  wire logic                      touch_expired,   // Touch held past limit
	output logic                           recal_restart,   // Restart recalibration
	input  wire logic                      press,           // Press detected
	input  wire logic                      release_evt,     // Release detected
	input  wire logic                      repeat_evt,      // Repeat tick
	output logic                           irq_event,       // Interrupt event pulse
	input  wire logic                      alert_req,       // Interrupt pending
	output logic                           alert_out,       // Alert pin output value
	output logic                           alert_oe,        // Alert pin output enable
	input  wire logic                      link_touch,      // Touch for linked LED
	output logic                           link_touch_out,  // Touch to LED transitions
	output logic                           duty_min_eq_max, // Transition min duty = max
	input  wire logic                      conv_idle,       // Between conversion and poll end
	output logic                           sense_powerdown, // Power down sensing
	input  wire logic                      pol_wr,          // LED polarity written
	input  wire logic [2:0]                pol_value,       // New LED polarity bits
	output logic                           mirror_load,     // Load LED mirror bits
	output logic      [2:0]                mirror_value,    // Value for mirror bits
	output logic                           sample_start,    // Start sampling an input
	output logic      [1:0]                sample_chan,     // Input being sampled
	output logic                           cycle_start      // Sampling cycle begins
);
	localparam int CYCLE_LEN = 3 * `SLOT_CYCLES;

	touch_cfg_pkg::core_state_t st;
	touch_cfg_pkg::core_state_t next_st;
	touch_cfg_pkg::link_state_t lk;
	touch_cfg_pkg::link_state_t next_lk;
	logic                       low_expired;
	logic                       idle_expired;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain

	always_comb begin
		next_lk = lk;
		next_lk.rvalid = 1'b0;
		next_lk.ack_s1 = st.ack;
		next_lk.ack_s2 = lk.ack_s1;
		next_lk.ack_s3 = lk.ack_s2;
		if (lk.busy && (lk.ack_s2 != lk.ack_s3)) begin
			next_lk.busy = 1'b0;
			next_lk.rvalid = lk.is_read;
			if (lk.is_read) begin
				next_lk.rdata = st.rdata;
			end
		end else if (!lk.busy && (link_wr || link_rd)) begin
			// Fields stay still while busy, so the other domain samples them safely
			next_lk.busy = 1'b1;
			next_lk.is_read = link_rd && !link_wr;
			next_lk.addr = link_addr;
			next_lk.wdata = link_wdata;
			next_lk.req = !lk.req;
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_srst) begin
			lk <= '0;
		end else begin
			lk <= next_lk;
		end
	end

	assign link_rdata = lk.rdata;
	assign link_rvalid = lk.rvalid;
	assign link_busy = lk.busy;

	////////////////////////////////////////////////////////////////////////////////
	// Bus line watchdogs

	bus_hold_timer #(
		.LIMIT(BUS_LOW_CYCLES)
	) u_low_timer (
		.clk    (clk),
		.srst   (srst),
		.enable (st.cfg_a[`BIT_TIMEOUT]),
		.cond   (!st.scl_s2),
		.expired(low_expired)
	);

	bus_hold_timer #(
		.LIMIT(BUS_IDLE_CYCLES)
	) u_idle_timer (
		.clk    (clk),
		.srst   (srst),
		.enable (st.cfg_a[`BIT_TIMEOUT]),
		.cond   (st.scl_s2 && st.sda_s2),
		.expired(idle_expired)
	);

	////////////////////////////////////////////////////////////////////////////////
	// System domain

	always_comb begin
		logic [2:0]         gain;
		logic [3:0]         bshift;
		logic signed [23:0] scaled;
		logic [7:0]         delta;
		logic               lf_block;
		logic               rf_block;
		logic               above_touch;
		logic               above_noise;
		gain = 3'h0;
		bshift = 4'h0;
		scaled = 24'sh0;
		delta = 8'h0;
		lf_block = 1'b0;
		rf_block = 1'b0;
		above_touch = 1'b0;
		above_noise = 1'b0;
		next_st = st;

		// Pin and request synchronisers
		next_st.scl_s1 = scl_pin;
		next_st.scl_s2 = st.scl_s1;
		next_st.sda_s1 = sda_pin;
		next_st.sda_s2 = st.sda_s1;
		next_st.req_s1 = lk.req;
		next_st.req_s2 = st.req_s1;
		next_st.req_s3 = st.req_s2;

		// Register access from the serial engine
		if (st.req_s2 != st.req_s3) begin
			next_st.ack = !st.ack;
			if (lk.is_read) begin
				case (lk.addr)
					`ADDR_TOUCH_SENS: next_st.rdata = st.sens;
					`ADDR_CFG_A:      next_st.rdata = st.cfg_a;
					`ADDR_SAMPLE_EN:  next_st.rdata = st.smp_en;
					`ADDR_CFG_B:      next_st.rdata = st.cfg_b;
					default:          next_st.rdata = 8'h00;
				endcase
			end else begin
				case (lk.addr)
					`ADDR_TOUCH_SENS: next_st.sens = lk.wdata & `MASK_TOUCH_SENS;
					`ADDR_CFG_A:      next_st.cfg_a = lk.wdata & `MASK_CFG_A;
					`ADDR_SAMPLE_EN:  next_st.smp_en = lk.wdata & `MASK_SAMPLE_EN;
					`ADDR_CFG_B:      next_st.cfg_b = lk.wdata & `MASK_CFG_B;
					default:          next_st.rdata = st.rdata;
				endcase
			end
		end

		next_st.bus_timeout = low_expired;
		next_st.bus_idle_reset = idle_expired;

		// Delta scaling and noise handling
		gain = st.sens[`GAIN_LSB +: 3];
		scaled = $signed({{8{smp.raw[15]}}, smp.raw}) <<< (`GAIN_MAX_SHIFT - gain);
		if (scaled > 24'sd127) begin
			delta = 8'h7F;
		end else if (scaled < -24'sd128) begin
			delta = 8'h80;
		end else begin
			delta = scaled[7:0];
		end
		lf_block = smp.lf_noise && !st.cfg_a[`BIT_LF_OFF];
		rf_block = smp.rf_noise && !st.cfg_b[`BIT_RF_OFF];
		if (lf_block || rf_block) begin
			delta = 8'h00;
		end
		above_touch = $signed({delta[7], delta}) > $signed({1'b0, smp.touch_thr});
		above_noise = $signed({delta[7], delta}) > $signed({1'b0, smp.noise_thr});
		next_st.dout.valid = smp.valid;
		next_st.dout.chan = smp.chan;
		next_st.dout.delta = delta;
		next_st.dout.touched = smp.valid && above_touch;
		if (st.cfg_a[`BIT_DIG_OFF]) begin
			next_st.dout.recal_use = smp.valid && ($signed({delta[7], delta}) < $signed({1'b0, smp.touch_thr}));
		end else begin
			next_st.dout.recal_use = smp.valid && !above_noise && !above_touch;
		end
		next_st.dout.noise_flag = smp.rf_noise || (smp.lf_noise && !st.cfg_b[`BIT_RF_ONLY]);

		// Base count presentation only
		bshift = (st.sens[`BASE_LSB +: 4] > `BASE_MAX_SHIFT) ? `BASE_MAX_SHIFT : st.sens[`BASE_LSB +: 4];
		next_st.base_out = base_valid ? (base_count >> bshift) : st.base_out;
		next_st.base_out_valid = base_valid;

		next_st.recal_restart = touch_expired && st.cfg_a[`BIT_LONG_RECAL];
		next_st.irq_event = press || repeat_evt || (release_evt && !st.cfg_b[`BIT_REL_SUPP]);

		// Alert pin drive
		if (st.cfg_b[`BIT_ALERT_POL]) begin
			next_st.alert_out = 1'b0;
			next_st.alert_oe = alert_req;
		end else begin
			next_st.alert_out = alert_req;
			next_st.alert_oe = 1'b1;
		end

		next_st.link_touch_out = link_touch ^ st.cfg_b[`BIT_LINK_INV];
		next_st.duty_min_eq_max = !st.cfg_b[`BIT_LINK_INV];
		next_st.sense_powerdown = conv_idle && !st.cfg_b[`BIT_PWR_BLK];
		next_st.mirror_load = pol_wr && !st.cfg_b[`BIT_MIR_DECOUPLE];
		next_st.mirror_value = pol_value;

		// Fixed-length sampling cycle, one slot per input
		next_st.sample_start = 1'b0;
		next_st.cycle_start = 1'b0;
		if (st.slot_cnt == 8'h00) begin
			next_st.sample_start = st.smp_en[st.slot_idx];
			next_st.sample_chan = st.slot_idx;
			next_st.cycle_start = (st.slot_idx == 2'h0);
		end
		if (st.slot_cnt == `SLOT_CYCLES - 8'h01) begin
			next_st.slot_cnt = 8'h00;
			next_st.slot_idx = (st.slot_idx == 2'h2) ? 2'h0 : st.slot_idx + 2'h1;
		end else begin
			next_st.slot_cnt = st.slot_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.sens <= `RST_TOUCH_SENS;
			st.cfg_a <= `RST_CFG_A;
			st.smp_en <= `RST_SAMPLE_EN;
			st.cfg_b <= `RST_CFG_B;
			st.duty_min_eq_max <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign bus_timeout = st.bus_timeout;
	assign bus_idle_reset = st.bus_idle_reset;
	assign dout = st.dout;
	assign base_out = st.base_out;
	assign base_out_valid = st.base_out_valid;
	assign recal_restart = st.recal_restart;
	assign irq_event = st.irq_event;
	assign alert_out = st.alert_out;
	assign alert_oe = st.alert_oe;
	assign link_touch_out = st.link_touch_out;
	assign duty_min_eq_max = st.duty_min_eq_max;
	assign sense_powerdown = st.sense_powerdown;
	assign mirror_load = st.mirror_load;
	assign mirror_value = st.mirror_value;
	assign sample_start = st.sample_start;
	assign sample_chan = st.sample_chan;
	assign cycle_start = st.cycle_start;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	chk_gain_unit: assert property (@(posedge clk) disable iff (srst)
		(smp.valid && smp.raw == 16'sh1 && !smp.lf_noise && !smp.rf_noise)
		|=> (($past(st.sens[`GAIN_LSB +: 3]) != 3'h0
			&& st.dout.delta == (8'h80 >> $past(st.sens[`GAIN_LSB +: 3])))
			|| ($past(st.sens[`GAIN_LSB +: 3]) == 3'h0 && st.dout.delta == 8'h7F)))
		else $error("delta not scaled by gain");

	chk_gain_reset: assert property (@(posedge clk) $past(srst) |-> st.sens[`GAIN_LSB +: 3] == 3'h2)
		else $error("gain reset value wrong");

	chk_base_scale: assert property (@(posedge clk) disable iff (srst)
		(base_valid && st.sens[`BASE_LSB +: 4] > 4'h8) |=> st.base_out == ($past(base_count) >> 8))
		else $error("base scale not capped at 256");

	chk_timeout_gate: assert property (@(posedge clk) disable iff (srst)
		(low_expired || idle_expired) |-> $past(st.cfg_a[`BIT_TIMEOUT]))
		else $error("bus watchdog fired while disabled");

	chk_lf_zero: assert property (@(posedge clk) disable iff (srst)
		(smp.lf_noise && !st.cfg_a[`BIT_LF_OFF]) |=> st.dout.delta == 8'h00)
		else $error("low-frequency noise did not zero delta");

	chk_rf_zero: assert property (@(posedge clk) disable iff (srst)
		(smp.rf_noise && !st.cfg_b[`BIT_RF_OFF]) |=> st.dout.delta == 8'h00)
		else $error("RF noise did not zero delta");

	chk_recal_noise: assert property (@(posedge clk) disable iff (srst)
		(st.dout.valid && !$past(st.cfg_a[`BIT_DIG_OFF]) && !st.dout.delta[7]
			&& st.dout.delta > $past(smp.noise_thr)) |-> !st.dout.recal_use)
		else $error("noisy sample fed recalibration");

	chk_release_skip: assert property (@(posedge clk) disable iff (srst)
		(release_evt && !press && !repeat_evt && st.cfg_b[`BIT_REL_SUPP]) |=> !st.irq_event)
		else $error("release raised interrupt while suppressed");

	chk_alert_push: assert property (@(posedge clk) disable iff (srst)
		!st.cfg_b[`BIT_ALERT_POL] |=> (st.alert_oe && st.alert_out == $past(alert_req)))
		else $error("alert not active-high push-pull");

	chk_sample_mask: assert property (@(posedge clk) disable iff (srst)
		st.sample_start |-> ((($past(st.smp_en) >> st.sample_chan) & 8'h01) == 8'h01))
		else $error("disabled input was sampled");

	chk_cycle_len: assert property (@(posedge clk) disable iff (srst)
		st.cycle_start |-> ##CYCLE_LEN st.cycle_start)
		else $error("sampling cycle length changed");

	chk_unused_zero: assert property (@(posedge clk) disable iff (srst)
		((st.cfg_a & ~`MASK_CFG_A) == 8'h00) && ((st.cfg_b & ~`MASK_CFG_B) == 8'h00))
		else $error("unused configuration bit set");

	cov_write: cover property (@(posedge clk) disable iff (srst)
		(st.req_s2 != st.req_s3) && !lk.is_read);
	cov_read: cover property (@(posedge link_clk) disable iff (link_srst) lk.rvalid);
	cov_timeout: cover property (@(posedge clk) disable iff (srst) st.bus_timeout);
	cov_idle: cover property (@(posedge clk) disable iff (srst) st.bus_idle_reset);

endmodule : touch_cfg_core

// ### link_host.sv
`timescale 1ns/1ps
module link_host (
	input  wire logic       link_clk,    // Link clock
	input  wire logic       link_busy,   // Access in flight
	input  wire logic       link_rvalid, // Read data strobe
	input  wire logic [7:0] link_rdata,  // Read data
	output logic            link_wr,     // Write request
	output logic            link_rd,     // Read request
	output logic      [7:0] link_addr,   // Register offset
	output logic      [7:0] link_wdata   // Write data
);
	initial begin
		link_wr = 1'b0;
		link_rd = 1'b0;
		link_addr = 8'h00;
		link_wdata = 8'h00;
	end
	// Hold request until taken, then scramble released lines
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(negedge link_clk);
		link_wr = w;
		link_rd = !w;
		link_addr = a;
		link_wdata = d;
		do begin
			@(negedge link_clk);
			n = n + 1;
		end while (link_busy !== 1'b1 && n < 40);
		link_wr = 1'b0;
		link_rd = 1'b0;
		link_addr = ~a;
		link_wdata = ~d;
		while (link_busy !== 1'b0 && n < 80) begin
			@(negedge link_clk);
			n = n + 1;
		end
		// Unknown result marks an access that never finished
		if (link_busy !== 1'b0)
			q = 8'hXX;
		else if (w)
			q = 8'h00;
		else if (link_rvalid === 1'b1)
			q = link_rdata;
		else
			q = 8'hXX;
	endtask : acc
endmodule : link_host

// ### touch_cfg_core_bench.sv
`timescale 1ns/1ps
module touch_cfg_core_bench;
	logic clk, srst, link_clk, link_srst, link_wr, link_rd, link_rvalid, link_busy, scl_pin, sda_pin;
	logic bus_timeout, bus_idle_reset, base_valid, base_out_valid, touch_expired, recal_restart;
	logic press, release_evt, repeat_evt, irq_event, alert_req, alert_out, alert_oe, link_touch;
	logic link_touch_out, duty_min_eq_max, conv_idle, sense_powerdown, pol_wr, mirror_load;
	logic sample_start, cycle_start;
	logic [7:0] link_addr, link_wdata, link_rdata;
	logic [15:0] base_count, base_out;
	logic [2:0] pol_value, mirror_value;
	logic [1:0] sample_chan, ch;
	touch_cfg_pkg::sample_in_t smp;
	touch_cfg_pkg::delta_out_t dout;
	int err_total, cmp_count, nto, nid, n, s;
	logic [7:0] adr[4] = '{8'h1F, 8'h20, 8'h21, 8'h44};
	logic [7:0] rst[4] = '{8'h2F, 8'h20, 8'h07, 8'h40};
	logic [7:0] msk[4] = '{8'h7F, 8'hB8, 8'h07, 8'hFD};

	touch_cfg_core #(.BUS_LOW_CYCLES(50), .BUS_IDLE_CYCLES(30)) DUT (
		.clk, .srst, .link_clk, .link_srst, .link_wr, .link_rd, .link_addr, .link_wdata, .link_rdata,
		.link_rvalid, .link_busy, .scl_pin, .sda_pin, .bus_timeout, .bus_idle_reset, .smp, .dout,
		.base_valid, .base_count, .base_out, .base_out_valid, .touch_expired, .recal_restart, .press,
		.release_evt, .repeat_evt, .irq_event, .alert_req, .alert_out, .alert_oe, .link_touch,
		.link_touch_out, .duty_min_eq_max, .conv_idle, .sense_powerdown, .pol_wr, .pol_value,
		.mirror_load, .mirror_value, .sample_start, .sample_chan, .cycle_start
	);
	link_host host (.link_clk, .link_busy, .link_rvalid, .link_rdata, .link_wr, .link_rd, .link_addr, .link_wdata);

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	always @(posedge clk) begin
		if (bus_timeout === 1'b1) nto++;
		if (bus_idle_reset === 1'b1) nid++;
	end
	initial begin
		#300000;
		err_total++;
		test_done();
	end

	////////////////////////////////////////////////////////////////
	task automatic tick;
		@(negedge clk);
	endtask : tick
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.acc(1'b1, a, d, q);
		chk("write done", 16'h0000, {8'h00, q});
		repeat (2) tick();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		host.acc(1'b0, a, 8'h00, q);
		chk($sformatf("reg %h", a), e, q);
	endtask : rd
	task automatic sm(input logic [15:0] r, input logic lf, input logic rf);
		smp.raw = r;
		smp.lf_noise = lf;
		smp.rf_noise = rf;
		smp.valid = 1'b1;
		tick();
		smp.valid = 1'b0;
	endtask : sm
	task automatic test_done;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////
	initial begin
		{srst, link_srst, scl_pin, sda_pin, alert_req, link_touch, conv_idle} = 7'h7F;
		{base_valid, touch_expired, press, release_evt, repeat_evt, pol_wr} = 6'h00;
		{err_total, cmp_count, nto, nid} = 0;
		base_count = 16'hFFFF;
		pol_value = 3'h5;
		smp = '0;
		smp.touch_thr = 8'h14;
		smp.noise_thr = 8'h0A;
		repeat (20) tick();
		srst = 1'b0;
		link_srst = 1'b0;
		tick();
		foreach (adr[i]) rd(adr[i], rst[i]);
		foreach (adr[i]) begin
			wr(adr[i], 8'hFF);
			rd(adr[i], msk[i]);
			wr(adr[i], rst[i]);
		end
		rd(8'h55, 8'h00);
		$display("Register test done");
		for (int g = 0; g < 8; g++) begin
			wr(8'h1F, 8'(g * 16 + 15));
			smp.chan = 2'(g);
			sm(16'h0001, 1'b0, 1'b0);
			chk("delta", g == 0 ? 16'h7F : 16'(1 << (7 - g)), dout.delta);
			chk("delta valid", 1, dout.valid);
			chk("delta chan", g % 4, dout.chan);
			chk("touched", g < 3, dout.touched);
		end
		for (int c = 0; c < 16; c++) begin
			wr(8'h1F, 8'(8'h70 + c));
			base_valid = 1'b1;
			tick();
			base_valid = 1'b0;
			chk("base", 16'hFFFF >> (c > 8 ? 8 : c), base_out);
			chk("base valid", 1, base_out_valid);
		end
		sm(16'h000F, 1'b0, 1'b0);
		chk("delta", 16'h0F, dout.delta);
		chk("recal use", 1, dout.recal_use);
		sm(16'h000F, 1'b1, 1'b0);
		chk("lf delta", 0, dout.delta);
		chk("noise flag", 1, dout.noise_flag);
		sm(16'h000F, 1'b0, 1'b1);
		chk("rf delta", 0, dout.delta);
		wr(8'h44, 8'h4C);
		sm(16'h000F, 1'b1, 1'b0);
		chk("lf delta", 0, dout.delta);
		chk("noise flag", 0, dout.noise_flag);
		sm(16'h000F, 1'b0, 1'b1);
		chk("rf delta", 16'h0F, dout.delta);
		for (int k = 0; k < 2; k++) begin
			wr(8'h20, k ? 8'h20 : 8'h18);
			sm(16'h000F, 1'b1, 1'b0);
			chk("lf delta", k ? 0 : 16'h0F, dout.delta);
			chk("recal use", k, dout.recal_use);
			touch_expired = 1'b1;
			tick();
			touch_expired = 1'b0;
			chk("recal restart", !k, recal_restart);
		end
		$display("Sample path test done");
		for (int k = 0; k < 2; k++) begin
			wr(8'h44, k ? 8'hB1 : 8'h40);
			chk("alert out", k, alert_out);
			chk("alert oe", 1, alert_oe);
			chk("link touch", !k, link_touch_out);
			chk("duty", !k, duty_min_eq_max);
			chk("power down", !k, sense_powerdown);
			{pol_wr, release_evt} = 2'b11;
			tick();
			{pol_wr, release_evt, press} = 3'b001;
			chk("mirror load", !k, mirror_load);
			chk("release irq", !k, irq_event);
			if (k == 0) chk("mirror value", 5, mirror_value);
			tick();
			press = 1'b0;
			chk("press irq", 1, irq_event);
		end
		$display("Control test done");
		for (int k = 0; k < 2; k++) begin
			wr(8'h20, k ? 8'hA0 : 8'h20);
			{nto, nid} = 0;
			scl_pin = 1'b0;
			repeat (80) tick();
			scl_pin = 1'b1;
			repeat (80) tick();
			chk("timeouts", k, 16'(nto));
			chk("idle resets", k, 16'(nid));
		end
		wr(8'h20, 8'h20);
		$display("Bus watchdog test done");
		for (int k = 0; k < 2; k++) begin
			wr(8'h21, k ? 8'h07 : 8'h02);
			n = 0;
			while (cycle_start !== 1'b1 && n < 200) begin
				tick();
				n++;
			end
			{n, s} = 0;
			do begin
				tick();
				n++;
				if (sample_start === 1'b1) s++;
				if (sample_start === 1'b1) ch = sample_chan;
			end while (cycle_start !== 1'b1 && n < 200);
			chk("cycle length", 60, 16'(n));
			chk("samples", k ? 3 : 1, 16'(s));
			if (k == 0) chk("sample chan", 1, ch);
		end
		$display("Sampler test done");
		test_done();
	end
endmodule : touch_cfg_core_bench
